// ==== src/fms_pkg.sv ====
// Package holding register map, field layouts and timing constants of the minislot supervisor.
package fms_pkg;
    localparam int unsigned CLK_MHZ = 125;
    // Macrotick duration limits in microseconds.
    localparam int unsigned MT_MIN_US = 1;
    localparam int unsigned MT_MAX_US = 6;
    localparam int unsigned MT_MIN_CYC = MT_MIN_US * CLK_MHZ;
    // Register byte offsets.
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_TIMING = 12'h004;
    localparam logic [11:0] REG_CYCLE = 12'h008;
    localparam logic [11:0] REG_THRESH = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_SEG = 12'h014;
    localparam logic [11:0] REG_EVENT = 12'h018;
    // Reset values.
    localparam logic [5:0] RST_MINISLOT = 6'h02;
    localparam logic [4:0] RST_ACTION = 5'h01;
    localparam logic [12:0] RST_NUM_MINI = 13'h0000;
    localparam logic [13:0] RST_DYN_START = 14'h0008;
    localparam logic [13:0] RST_CYCLE_US = 14'h03E8;
    localparam logic [13:0] RST_MT_PER_CYC = 14'h03E8;
    localparam logic [3:0] RST_PAS_THR = 4'h1;
    localparam logic [3:0] RST_FAT_THR = 4'h1;
    localparam logic [10:0] RST_SLOT_ID = 11'h001;

    typedef enum logic [2:0] {
        FMS_ACTIVE = 3'b001,
        FMS_PASSIVE = 3'b010,
        FMS_HALT = 3'b100
    } fms_poc_e;

    // Dynamic-segment configuration fields, carried together.
    typedef struct packed {
        logic [5:0] minislot_duration;
        logic [4:0] minislot_action_offset;
        logic [12:0] num_minislots;
        logic [13:0] dyn_start;
    } fms_dyn_cfg_s;

    // Per-macrotick status word seen by the transmit side.
    typedef struct packed {
        logic in_dynamic;
        logic action_point;
        logic [10:0] slot_id;
    } fms_dyn_stat_s;
endpackage

// ==== src/fms_supervisor.sv ====
// Minislot timing and clock correction supervisor with an APB register file.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module fms_supervisor #(
    parameter int unsigned CYC_W = 14
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cycle_start_i,
    input wire logic pair_end_i,
    input wire logic corr_valid_i,
    input wire logic tx_pending_i,
    input wire logic tx_busy_i,
    output logic mt_tick_o,
    output logic tx_start_o,
    output fms_pkg::fms_dyn_stat_s dyn_stat_o,
    output fms_pkg::fms_poc_e poc_state_o
);
    import fms_pkg::*;

    // Configuration and state registers.
    logic enable, next_enable;
    fms_dyn_cfg_s cfg, next_cfg;
    logic [13:0] cycle_us, next_cycle_us;
    logic [13:0] mt_per_cyc, next_mt_per_cyc;
    logic [3:0] pas_thr, next_pas_thr;
    logic [3:0] fat_thr, next_fat_thr;
    logic [31:0] prdata, next_prdata;
    logic pready, next_pready;
    logic pslverr, next_pslverr;
    logic [2:0] mt_us, next_mt_us;
    logic [9:0] mt_cnt, next_mt_cnt;
    logic mt_tick, next_mt_tick;
    logic [13:0] mt_in_cyc, next_mt_in_cyc;
    logic [5:0] ms_pos, next_ms_pos;
    logic [12:0] ms_idx, next_ms_idx;
    logic in_dyn, next_in_dyn;
    logic slot_used, next_slot_used;
    logic [10:0] slot_id, next_slot_id;
    logic act_pt, next_act_pt;
    logic tx_start, next_tx_start;
    logic [3:0] fail_cnt, next_fail_cnt;
    fms_poc_e poc, next_poc;
    logic ovf_flag, next_ovf_flag;

    // Rounded division of cycle duration by macroticks, clamped to the legal range.
    function automatic logic [2:0] mt_round(input logic [13:0] cyc, input logic [13:0] mpc);
        logic [14:0] q;
        q = 15'h0000;
        if (mpc != 14'h0000) begin
            q = 15'(({1'b0, cyc} + {2'b00, mpc[13:1]}) / {1'b0, mpc});
        end
        if (q < 15'(MT_MIN_US)) begin
            return 3'(MT_MIN_US);
        end else if (q > 15'(MT_MAX_US)) begin
            return 3'(MT_MAX_US);
        end
        return q[2:0];
    endfunction

    // APB slave: single-cycle access phase, unmapped offsets answer with an error.
    always_comb begin
        next_enable = enable;
        next_cfg = cfg;
        next_cycle_us = cycle_us;
        next_mt_per_cyc = mt_per_cyc;
        next_pas_thr = pas_thr;
        next_fat_thr = fat_thr;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_ovf_flag = ovf_flag;
        next_pready = psel_i && !penable_i;
        if (psel_i && !penable_i) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr_i)
                REG_CTRL: next_prdata = {31'h0, enable};
                REG_TIMING: next_prdata = {8'h0, cfg.num_minislots, cfg.minislot_action_offset,
                    cfg.minislot_duration};
                REG_CYCLE: next_prdata = {2'h0, mt_per_cyc, 2'h0, cycle_us};
                REG_THRESH: next_prdata = {24'h0, fat_thr, pas_thr};
                REG_STATUS: next_prdata = {14'h0, slot_id, fail_cnt, poc};
                // Zero minislots: no dynamic segment.
                // report zero start
                REG_SEG: next_prdata = {15'h0, mt_us,
                    (cfg.num_minislots == 13'h0000) ? 14'h0000 : cfg.dyn_start};
                REG_EVENT: next_prdata = {31'h0, ovf_flag};
                default: next_pslverr = 1'b1;
            endcase
            if (paddr_i > REG_EVENT || paddr_i[1:0] != 2'b00) begin
                next_pslverr = 1'b1;
            end
        end
        if (psel_i && penable_i && pwrite_i && pready) begin
            unique case (paddr_i)
                REG_CTRL: next_enable = pwdata_i[0];
                REG_TIMING: begin
                    if (pwdata_i[5:0] >= RST_MINISLOT) begin
                        next_cfg.minislot_duration = pwdata_i[5:0];
                    end
                    if (pwdata_i[10:6] != 5'h00) begin
                        next_cfg.minislot_action_offset = pwdata_i[10:6];
                    end
                    next_cfg.num_minislots = pwdata_i[23:11];
                end
                REG_CYCLE: begin
                    next_cycle_us = pwdata_i[13:0];
                    next_mt_per_cyc = pwdata_i[29:16];
                end
                REG_THRESH: begin
                    next_pas_thr = pwdata_i[3:0];
                    next_fat_thr = pwdata_i[7:4];
                end
                REG_SEG: next_cfg.dyn_start = pwdata_i[13:0];
                default: begin
                end
            endcase
        end
        // Slot overflow sticky flag; a set in the clearing cycle wins.
        if (psel_i && penable_i && pwrite_i && pready && paddr_i == REG_EVENT && pwdata_i[0]) begin
            next_ovf_flag = 1'b0;
        end
        if (mt_tick && in_dyn && slot_id == 11'h7FF && !slot_used) begin
            next_ovf_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            enable <= 1'b0;
            cfg <= '{RST_MINISLOT, RST_ACTION, RST_NUM_MINI, RST_DYN_START};
            cycle_us <= RST_CYCLE_US;
            mt_per_cyc <= RST_MT_PER_CYC;
            pas_thr <= RST_PAS_THR;
            fat_thr <= RST_FAT_THR;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ovf_flag <= 1'b0;
        end else begin
            enable <= next_enable;
            cfg <= next_cfg;
            cycle_us <= next_cycle_us;
            mt_per_cyc <= next_mt_per_cyc;
            pas_thr <= next_pas_thr;
            fat_thr <= next_fat_thr;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ovf_flag <= next_ovf_flag;
        end
    end

    // Macrotick generator and dynamic segment sequencer.
    always_comb begin
        next_mt_us = mt_round(cycle_us, mt_per_cyc);
        next_mt_cnt = mt_cnt;
        next_mt_tick = 1'b0;
        next_mt_in_cyc = mt_in_cyc;
        next_ms_pos = ms_pos;
        next_ms_idx = ms_idx;
        next_in_dyn = in_dyn;
        next_slot_used = slot_used;
        next_slot_id = slot_id;
        next_act_pt = 1'b0;
        next_tx_start = 1'b0;
        if (enable) begin
            if (mt_cnt >= 10'(mt_us * CLK_MHZ) - 10'h001) begin
                next_mt_cnt = 10'h000;
                next_mt_tick = 1'b1;
            end else begin
                next_mt_cnt = mt_cnt + 10'h001;
            end
        end else begin
            next_mt_cnt = 10'h000;
        end
        if (cycle_start_i) begin
            next_mt_in_cyc = 14'h0000;
            next_in_dyn = 1'b0;
            next_slot_id = RST_SLOT_ID;
        end else if (mt_tick) begin
            next_mt_in_cyc = mt_in_cyc + 14'h0001;
            if (mt_in_cyc + 14'h0001 == cfg.dyn_start && cfg.num_minislots != 13'h0000) begin
                next_in_dyn = 1'b1;
                next_ms_pos = 6'h00;
                next_ms_idx = 13'h0000;
                next_slot_used = 1'b0;
            end else if (in_dyn) begin
                // action point offset
                // The offset counts whole macroticks, so the point lands on the tick ending
                // macrotick number offset-1 of the minislot, never one tick late.
                if (ms_pos + 6'h01 == 6'(cfg.minislot_action_offset)) begin
                    next_act_pt = 1'b1;
                    if (tx_pending_i && !slot_used) begin
                        next_tx_start = 1'b1;
                        next_slot_used = 1'b1;
                    end
                end
                if (ms_pos == cfg.minislot_duration - 6'h01) begin
                    next_ms_pos = 6'h00;
                    next_ms_idx = ms_idx + 13'h0001;
                    if (!slot_used || !tx_busy_i) begin
                        next_slot_id = slot_id + 11'h001;
                        next_slot_used = 1'b0;
                    end
                    if (ms_idx + 13'h0001 == cfg.num_minislots) begin
                        next_in_dyn = 1'b0;
                    end
                end else begin
                    next_ms_pos = ms_pos + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            mt_us <= 3'(MT_MIN_US);
            mt_cnt <= 10'h000;
            mt_tick <= 1'b0;
            mt_in_cyc <= 14'h0000;
            ms_pos <= 6'h00;
            ms_idx <= 13'h0000;
            in_dyn <= 1'b0;
            slot_used <= 1'b0;
            slot_id <= RST_SLOT_ID;
            act_pt <= 1'b0;
            tx_start <= 1'b0;
        end else begin
            mt_us <= next_mt_us;
            mt_cnt <= next_mt_cnt;
            mt_tick <= next_mt_tick;
            mt_in_cyc <= next_mt_in_cyc;
            ms_pos <= next_ms_pos;
            ms_idx <= next_ms_idx;
            in_dyn <= next_in_dyn;
            slot_used <= next_slot_used;
            slot_id <= next_slot_id;
            act_pt <= next_act_pt;
            tx_start <= next_tx_start;
        end
    end

    // Clock correction supervision; halt is left only by reset.
    always_comb begin
        next_fail_cnt = fail_cnt;
        next_poc = poc;
        if (pair_end_i && poc != FMS_HALT) begin
            if (corr_valid_i) begin
                next_fail_cnt = 4'h0;
            end else if (fail_cnt != 4'hF) begin
                next_fail_cnt = fail_cnt + 4'h1;
            end
            if (!corr_valid_i && fail_cnt + 4'h1 >= fat_thr) begin
                next_poc = FMS_HALT;
            end else if (!corr_valid_i && poc == FMS_ACTIVE && fail_cnt + 4'h1 >= pas_thr) begin
                next_poc = FMS_PASSIVE;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            fail_cnt <= 4'h0;
            poc <= FMS_ACTIVE;
        end else begin
            fail_cnt <= next_fail_cnt;
            poc <= next_poc;
        end
    end

    assign prdata_o = prdata;
    assign pready_o = pready;
    assign pslverr_o = pslverr;
    assign mt_tick_o = mt_tick;
    assign tx_start_o = tx_start;
    assign dyn_stat_o = '{in_dyn, act_pt, slot_id};
    assign poc_state_o = poc;

    // Checks on the supervision and sequencing logic.
    // Halt follows an uncorrected pair at the fatal threshold.
    property p_halt;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (pair_end_i && !corr_valid_i && poc != FMS_HALT && fail_cnt + 4'h1 >= fat_thr)
            |=> poc == FMS_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("fatal threshold did not halt");
    property p_passive;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (pair_end_i && !corr_valid_i && poc == FMS_ACTIVE && fail_cnt + 4'h1 >= pas_thr)
            |=> poc != FMS_ACTIVE;
    endproperty
    a_passive: assert property (p_passive) else $error("passive threshold missed");
    property p_clear;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (pair_end_i && corr_valid_i && poc != FMS_HALT) |=> fail_cnt == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("failure count not cleared");
    property p_halt_sticky;
        @(posedge core_clk_i) disable iff (!resetn_i)
        poc == FMS_HALT |=> poc == FMS_HALT;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt left");
    property p_tx_at_act;
        @(posedge core_clk_i) disable iff (!resetn_i)
        tx_start |-> act_pt && in_dyn;
    endproperty
    a_tx_at_act: assert property (p_tx_at_act) else $error("start off action point");
    property p_act_pos;
        @(posedge core_clk_i) disable iff (!resetn_i)
        act_pt |-> $past(ms_pos) + 6'h01 == 6'(cfg.minislot_action_offset);
    endproperty
    a_act_pos: assert property (p_act_pos) else $error("action point misplaced");
    property p_slot_adv;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (mt_tick && in_dyn && !cycle_start_i && !slot_used
            && ms_pos == cfg.minislot_duration - 6'h01) |=> slot_id == $past(slot_id) + 11'h001;
    endproperty
    a_slot_adv: assert property (p_slot_adv) else $error("empty slot not advanced");
    property p_mt_range;
        @(posedge core_clk_i) disable iff (!resetn_i)
        mt_us >= 3'(MT_MIN_US) && mt_us <= 3'(MT_MAX_US);
    endproperty
    a_mt_range: assert property (p_mt_range) else $error("macrotick out of range");
    c_halt: cover property (@(posedge core_clk_i) disable iff (!resetn_i) poc == FMS_HALT);
    c_passive: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        poc == FMS_PASSIVE);
    c_tx: cover property (@(posedge core_clk_i) disable iff (!resetn_i) tx_start);
endmodule

// ==== sim/fms_node_model.sv ====
// Far-side node model that keeps the bus busy for one whole dynamic frame.
`timescale 1ns/1ps
module fms_node_model #(
    parameter int unsigned FRAME_MT = 3
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic mt_tick_i,
    input wire logic tx_start_i,
    output logic tx_busy_o
);
    int unsigned left;

    // frame spans minislots
    // The frame is counted in macroticks so that it straddles minislot ends.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            left <= 0;
        end else if (tx_start_i) begin
            left <= FRAME_MT;
        end else if (mt_tick_i && left != 0) begin
            left <= left - 1;
        end
    end

    // Busy is a level that drops as soon as the frame has ended.
    assign tx_busy_o = (left != 0);
endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the minislot supervisor.
`timescale 1ns/1ps
module tb;
    import fms_pkg::*;
    typedef struct {
        logic [3:0] pas;
        logic [3:0] fat;
        int nfail;
        logic ok_last;
        fms_poc_e poc;
        logic [3:0] cnt;
        logic [13:0] us;
        logic [2:0] mt;
    } fms_row_s;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mt_tick, tx_start, tx_busy;
    logic cycle_start = 1'b0;
    logic pair_end = 1'b0;
    logic corr_valid = 1'b0;
    logic tx_pending = 1'b0;
    logic want_tx = 1'b0;
    fms_dyn_stat_s dyn_stat;
    fms_poc_e poc_state;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int ticks, txs;
    logic [31:0] rd;
    logic [10:0] ap_slot;
    logic [10:0] tx_slot;
    logic err;
    fms_row_s rows [7] = '{
        '{4'h1, 4'h1, 1, 1'b0, FMS_HALT, 4'h1, 14'h03E8, 3'h1},
        '{4'h2, 4'h4, 2, 1'b0, FMS_PASSIVE, 4'h2, 14'h0960, 3'h2},
        '{4'h2, 4'h4, 1, 1'b0, FMS_ACTIVE, 4'h1, 14'h0A28, 3'h3},
        '{4'h2, 4'h4, 4, 1'b0, FMS_HALT, 4'h4, 14'h1388, 3'h5},
        '{4'h3, 4'h3, 3, 1'b0, FMS_HALT, 4'h3, 14'h2328, 3'h6},
        '{4'h3, 4'h5, 2, 1'b1, FMS_ACTIVE, 4'h0, 14'h0190, 3'h1},
        '{4'hF, 4'hF, 14, 1'b0, FMS_ACTIVE, 4'hE, 14'h03E8, 3'h1}};

    fms_supervisor u_fms_supervisor (.core_clk_i(core_clk), .resetn_i(resetn),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cycle_start_i(cycle_start), .pair_end_i(pair_end), .corr_valid_i(corr_valid),
        .tx_pending_i(tx_pending), .tx_busy_i(tx_busy), .mt_tick_o(mt_tick),
        .tx_start_o(tx_start), .dyn_stat_o(dyn_stat), .poc_state_o(poc_state));
    fms_node_model u_fms_node_model (.core_clk_i(core_clk), .resetn_i(resetn),
        .mt_tick_i(mt_tick), .tx_start_i(tx_start), .tx_busy_o(tx_busy));

    // Clock of 8 ns period.
    always #4 core_clk = ~core_clk;

    // A frame is pending only for the second slot, and only when asked for.
    always @(posedge core_clk) begin
        tx_pending <= want_tx && (dyn_stat.slot_id == 11'h002);
    end

    // Hang guard; the full run needs well under this many cycles.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end

    task automatic summarize();
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data,
        output logic [31:0] rdat, output logic perr);
        int w;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        w = 0;
        // Only the hang guard ends a wait that never sees pready.
        do begin
            @(posedge core_clk);
            w++;
        end while (pready !== 1'b1);
        // Zero wait states: pready is due in the first access cycle.
        chk("pready_wait", 32'h1, 32'(w));
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
    endtask

    // Pair end pulse, then room for the one-edge halt latency.
    task automatic pair(input logic ok);
        @(posedge core_clk);
        pair_end <= 1'b1;
        corr_valid <= ok;
        @(posedge core_clk);
        pair_end <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic pulse_cycle();
        @(posedge core_clk);
        cycle_start <= 1'b1;
        @(posedge core_clk);
        cycle_start <= 1'b0;
    endtask

    // Waits for the next action point, counting ticks and frame starts.
    task automatic wait_ap();
        ticks = 0;
        for (int w = 0; w < 3000; w++) begin
            @(posedge core_clk);
            if (mt_tick === 1'b1) ticks++;
            if (tx_start === 1'b1) begin
                txs++;
                tx_slot = dyn_stat.slot_id;
                chk("tx_at_ap", 32'h1, {31'h0, dyn_stat.action_point});
            end
            if (dyn_stat.action_point === 1'b1) begin
                ap_slot = dyn_stat.slot_id;
                chk("in_dyn", 32'h1, {31'h0, dyn_stat.in_dynamic});
                return;
            end
        end
        chk("ap_seen", 32'h1, 32'h0);
    endtask

    initial begin
        do_reset();
        apb(1'b0, REG_STATUS, 32'h0, rd, err);
        chk("status_rst", 32'h00000081, rd);
        apb(1'b0, REG_SEG, 32'h0, rd, err);
        chk("seg_start", 32'h0, {18'h0, rd[13:0]});
        chk("seg_mt", 32'h1, {29'h0, rd[16:14]});
        apb(1'b0, REG_EVENT, 32'h0, rd, err);
        chk("ovf_rst", 32'h0, rd);
        apb(1'b0, 12'h01C, 32'h0, rd, err);
        chk("unmapped", 32'h1, {31'h0, err});
        // Supervision and macrotick rounding, one fresh reset per row.
        foreach (rows[i]) begin
            do_reset();
            apb(1'b1, REG_THRESH, {24'h0, rows[i].fat, rows[i].pas}, rd, err);
            apb(1'b1, REG_CYCLE, {2'h0, 14'h03E8, 2'h0, rows[i].us}, rd, err);
            for (int n = 0; n < rows[i].nfail; n++) pair(1'b0);
            if (rows[i].ok_last) pair(1'b1);
            apb(1'b0, REG_STATUS, 32'h0, rd, err);
            chk("poc", {29'h0, rows[i].poc}, {29'h0, rd[2:0]});
            chk("fail_cnt", {28'h0, rows[i].cnt}, {28'h0, rd[6:3]});
            chk("poc_pin", {29'h0, rows[i].poc}, {29'h0, poc_state});
            apb(1'b0, REG_SEG, 32'h0, rd, err);
            chk("mt_us", {29'h0, rows[i].mt}, {29'h0, rd[16:14]});
        end
        // The last row sits one failed pair short of fatal, so one more halts.
        pair(1'b0);
        chk("halt_reach", {29'h0, FMS_HALT}, {29'h0, poc_state});
        // Halt is kept even after a good pair, until a reset in mid-run.
        pair(1'b1);
        chk("halt_kept", {29'h0, FMS_HALT}, {29'h0, poc_state});
        do_reset();
        @(posedge core_clk);
        chk("poc_after_rst", {29'h0, FMS_ACTIVE}, {29'h0, poc_state});
        // Dynamic segment: three minislots of 3 MT, action point 2 MT in.
        // segment fits the cycle
        apb(1'b1, REG_TIMING, {8'h0, 13'h0003, 5'h02, 6'h03}, rd, err);
        apb(1'b1, REG_CTRL, 32'h1, rd, err);
        apb(1'b0, REG_SEG, 32'h0, rd, err);
        chk("seg_start_dyn", 32'h8, {18'h0, rd[13:0]});
        for (int c = 0; c < 2; c++) begin
            want_tx <= (c == 1);
            txs = 0;
            pulse_cycle();
            for (int k = 0; k < 3; k++) begin
                wait_ap();
                // First point: segment start of 8 MT plus an offset of 2 MT.
                if (k == 0) chk("ap_pos", 32'h0000000A, ticks);
                if (k > 0) chk("ms_len", 32'h3, ticks);
                chk("slot_id", (c == 1 && k == 2) ? 2 : k + 1, {21'h0, ap_slot});
            end
            chk("tx_count", c, txs);
        end
        chk("tx_slot", 32'h2, {21'h0, tx_slot});
        summarize();
    end
endmodule
